// >>> logic/ofw_pkg.sv
/*
 * ofw_pkg: constants, register offsets and carrier types for the
 * overclock frequency watchdog block.
 * assumes a single 200 MHz reference clock and a byte-wide register port.
 */
package ofw_pkg;
  // register offsets (byte index on the plain register port)
  localparam logic [7:0] OFW_A_CPU_N_LO = 8'h00;
  localparam logic [7:0] OFW_A_CPU_CTRL = 8'h01; // [0]=n msb [1]=enable
  localparam logic [7:0] OFW_A_CPU_M    = 8'h02;
  localparam logic [7:0] OFW_A_SRC_N_LO = 8'h03;
  localparam logic [7:0] OFW_A_SRC_CTRL = 8'h04; // [0]=n msb [1]=enable
  localparam logic [7:0] OFW_A_SW_CPU_FREQ_CODE     = 8'h05; // [3:0] code [4] source sel
  localparam logic [7:0] OFW_A_SMOOTH   = 8'h06; // [0] manual [1] to src
  localparam logic [7:0] OFW_A_WD_CTRL  = 8'h07;
  localparam logic [7:0] OFW_A_REC_N_LO = 8'h08;
  localparam logic [7:0] OFW_A_REC_CTRL = 8'h09; // [0]=rec n msb
  localparam logic [7:0] OFW_A_STATUS   = 8'h0a;
  localparam logic [7:0] OFW_A_EFF_N_LO = 8'h0b;
  localparam logic [7:0] OFW_A_EFF_M    = 8'h0c;
  // watchdog control field positions
  localparam int OFW_WDOG_ENABLE_BIT_BIT    = 0;
  localparam int OFW_WD_TIMER_LSB = 1;
  localparam int OFW_WD_SCALE_BIT = 4;
  localparam int OFW_WD_RMODE_BIT = 5;
  localparam int OFW_WD_RECOV_BIT = 6;
  localparam int OFW_WD_AUTO_BIT  = 7;
  // reset values
  localparam logic [8:0] OFW_N_RST      = 9'h000;
  localparam logic [6:0] OFW_M_RST      = 7'h00;
  localparam logic [2:0] OFW_TIMER_RST  = 3'h0;
  localparam logic       OFW_SCALE_RST  = 1'b1;
  localparam logic       OFW_AUTO_RST   = 1'b1;
  localparam logic [2:0] OFW_TIMER_TEST = 3'h0;
  // timing
  localparam longint OFW_CLK_HZ     = 200000000;
  localparam longint OFW_PULSE_MS   = 20;
  localparam longint OFW_SCALE0_MS  = 250;
  localparam longint OFW_SCALE1_MS  = 3000;
  localparam longint OFW_PULSE_CYC  = OFW_CLK_HZ / 1000 * OFW_PULSE_MS;
  localparam longint OFW_SCALE0_CYC = OFW_CLK_HZ / 1000 * OFW_SCALE0_MS;
  localparam longint OFW_SCALE1_CYC = OFW_CLK_HZ / 1000 * OFW_SCALE1_MS;

  typedef struct packed {
    logic [8:0] n;
    logic [6:0] m;
  } ofw_nm_s;

  typedef enum {OFW_WD_IDLE, OFW_WD_COUNT, OFW_WD_PULSE, OFW_WD_DONE} ofw_wd_e;
endpackage

// >>> logic/ofw_overclock_freq_watchdog.sv
/*
 * ofw_overclock_freq_watchdog: programmable N/M frequency control, software
 * frequency select override, smooth switch assignment and watchdog timer.
 * assumes the serial management slave presents single-cycle strobes on a
 * plain register port; straps are stable before power good goes low.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - prog mode on: frequency is gear times N over M, gear from freq select
// - src pll: only N programmable, M fixed per selected frequency
// - cpu and src enables reset 0; set selects that pll's N/M
// - cpu M is 7 bits, reset 0
// - cpu N and src N are 9 bits, reset 0
// - recovery only for cpu prog mode; src has none
// - 4-bit software freq code; override bit picks straps or software
// - one shared smooth switch, auto default, manual assigns by bit
// - smooth switched change ramps glitch free within 2 percent
// - expiry drives a 20 ms system reset pulse
// - countdown from timer times scale; zero gives reset and alarm flag
// - reset output usable only if strap sampled low at power good
// - timer or scale write during countdown restarts from new value
// - after pulse stay idle until new timer/scale or enable re-set
// - enable resets 0; rising edge reloads the timer
// - timer field 3 bits, reset 000; 000 is reserved test mode
// - scale bit: 250 ms when clear, 3 s when set, reset 1
// - reset mode 0: pulse plus recovery; 1: pulse only
// - recovery mode 0: hardware latched; 1: user recovery N
// - autorecovery resets 1: device writes recovery value; else user
// - autorecovery: enable set captures N and M; timeout reloads them
module ofw_overclock_freq_watchdog
  import ofw_pkg::*;
#(
  parameter longint PULSE_CYC  = OFW_PULSE_CYC,
  parameter longint SCALE0_CYC = OFW_SCALE0_CYC,
  parameter longint SCALE1_CYC = OFW_SCALE1_CYC
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic [4:0] freq_select_straps,
  input  wire logic       system_reset_strap,
  input  wire logic       vtt_power_good_n,
  input  wire logic [8:0] hw_strap_n,
  input  wire logic [6:0] hw_strap_m,
  input  wire logic [6:0] src_table_m,
  output logic      [4:0] cpu_freq_code,
  output ofw_nm_s         cpu_pll_nm,
  output ofw_nm_s         src_pll_nm,
  output logic            smooth_to_src,
  output logic            smooth_active,
  output logic            system_reset_out_n
);
  // register state
  logic [8:0] cpu_n_r, src_n_r, rec_n_r;
  logic [6:0] cpu_m_r, rec_m_r;
  logic       cpu_en_r, src_en_r, override_r, sm_manual_r, sm_src_r;
  logic [3:0] sw_cpu_freq_code_r;
  logic       wdog_enable_bit_r, scale_r, rmode_r, recmode_r, auto_r, alarm_r;
  logic [2:0] timer_r;
  logic       booted_r, srst_ok_r;
  logic [4:0] straps_r;
  logic [8:0] hw_n_r;
  logic [6:0] hw_m_r;
  ofw_wd_e    wd_state_r, wd_state_nxt;
  logic [31:0] pre_r, pulse_r;
  logic [5:0]  ticks_r;
  logic [7:0]  rdata_nxt;

  function automatic logic wr_at(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  wire w_cpu_lo  = reg_write && wr_at(reg_addr, OFW_A_CPU_N_LO);
  wire w_cpu_ct  = reg_write && wr_at(reg_addr, OFW_A_CPU_CTRL);
  wire w_cpu_m   = reg_write && wr_at(reg_addr, OFW_A_CPU_M);
  wire w_src_lo  = reg_write && wr_at(reg_addr, OFW_A_SRC_N_LO);
  wire w_src_ct  = reg_write && wr_at(reg_addr, OFW_A_SRC_CTRL);
  wire w_sw_cpu_freq_code    = reg_write && wr_at(reg_addr, OFW_A_SW_CPU_FREQ_CODE);
  wire w_smooth  = reg_write && wr_at(reg_addr, OFW_A_SMOOTH);
  wire w_wd      = reg_write && wr_at(reg_addr, OFW_A_WD_CTRL);
  wire w_rec_lo  = reg_write && wr_at(reg_addr, OFW_A_REC_N_LO);
  wire w_rec_ct  = reg_write && wr_at(reg_addr, OFW_A_REC_CTRL);
  wire w_status  = reg_write && wr_at(reg_addr, OFW_A_STATUS);

  wire [2:0] new_timer = reg_wdata[OFW_WD_TIMER_LSB +: 3];
  wire       new_scale = reg_wdata[OFW_WD_SCALE_BIT];
  wire       new_en    = reg_wdata[OFW_WDOG_ENABLE_BIT_BIT];
  // enable rising edge or changed timer/scale reloads the countdown
  wire wd_rise   = w_wd && new_en && !wdog_enable_bit_r;
  wire wd_change = w_wd && (new_timer != timer_r || new_scale != scale_r);
  // a write that also clears the enable must never start a countdown
  wire wd_reload = wd_rise || (wd_change && new_en);
  wire wd_drop   = w_wd && !new_en;

  wire [31:0] scale_len = scale_r ? 32'(SCALE1_CYC) : 32'(SCALE0_CYC);
  wire        tick      = (pre_r == 32'h0);
  wire        counting  = (wd_state_r == OFW_WD_COUNT);
  wire        expire    = counting && tick && ticks_r == 6'h1;
  // recovery only touches the cpu pll, and only in reset-and-recover mode
  wire        do_recover = expire && !rmode_r && cpu_en_r;

  // hardware-latched or user/captured recovery value
  wire [8:0] rec_n_sel = recmode_r ? rec_n_r : hw_n_r;
  wire [6:0] rec_m_sel = recmode_r ? rec_m_r : hw_m_r;

  // straps, hardware n/m and reset strap caught once at power good
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      booted_r  <= 1'b0;
      srst_ok_r <= 1'b0;
      straps_r  <= 5'h00;
      hw_n_r    <= OFW_N_RST;
      hw_m_r    <= OFW_M_RST;
    end else if (!booted_r && !vtt_power_good_n) begin
      booted_r  <= 1'b1;
      srst_ok_r <= !system_reset_strap;
      straps_r  <= freq_select_straps;
      hw_n_r    <= hw_strap_n;
      hw_m_r    <= hw_strap_m;
    end
  end

  // frequency registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cpu_n_r <= OFW_N_RST;
      cpu_m_r <= OFW_M_RST;
      src_n_r <= OFW_N_RST;
      cpu_en_r <= 1'b0;
      src_en_r <= 1'b0;
      sw_cpu_freq_code_r <= 4'h0;
      override_r <= 1'b0;
      sm_manual_r <= 1'b0;
      sm_src_r <= 1'b0;
    end else begin
      if (do_recover) begin
        cpu_n_r <= rec_n_sel;
        cpu_m_r <= rec_m_sel;
      end else begin
        if (w_cpu_lo) cpu_n_r[7:0] <= reg_wdata;
        if (w_cpu_ct) cpu_n_r[8] <= reg_wdata[0];
        if (w_cpu_m) cpu_m_r <= reg_wdata[6:0];
      end
      if (w_cpu_ct) cpu_en_r <= reg_wdata[1];
      if (w_src_lo) src_n_r[7:0] <= reg_wdata;
      if (w_src_ct) begin
        src_n_r[8] <= reg_wdata[0];
        src_en_r   <= reg_wdata[1];
      end
      if (w_sw_cpu_freq_code) begin
        sw_cpu_freq_code_r     <= reg_wdata[3:0];
        override_r <= reg_wdata[4];
      end
      if (w_smooth) begin
        sm_manual_r <= reg_wdata[0];
        sm_src_r    <= reg_wdata[1];
      end
    end
  end

  // watchdog control and recovery registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wdog_enable_bit_r   <= 1'b0;
      timer_r   <= OFW_TIMER_RST;
      scale_r   <= OFW_SCALE_RST;
      rmode_r   <= 1'b0;
      recmode_r <= 1'b0;
      auto_r    <= OFW_AUTO_RST;
      rec_n_r   <= OFW_N_RST;
      rec_m_r   <= OFW_M_RST;
      alarm_r   <= 1'b0;
    end else begin
      if (w_wd) begin
        wdog_enable_bit_r   <= new_en;
        timer_r   <= new_timer;
        scale_r   <= new_scale;
        rmode_r   <= reg_wdata[OFW_WD_RMODE_BIT];
        recmode_r <= reg_wdata[OFW_WD_RECOV_BIT];
        auto_r    <= reg_wdata[OFW_WD_AUTO_BIT];
      end
      // capture on enable set; m always captured, n only in autorecovery
      if (wd_rise) begin
        rec_m_r <= cpu_m_r;
        if (auto_r) rec_n_r <= cpu_n_r;
      end else if (!auto_r) begin
        if (w_rec_lo) rec_n_r[7:0] <= reg_wdata;
        if (w_rec_ct) rec_n_r[8] <= reg_wdata[0];
      end
      // set wins over a same-cycle clear
      if (expire) alarm_r <= 1'b1;
      else if (w_status && reg_wdata[0]) alarm_r <= 1'b0;
    end
  end

  // watchdog sequencer
  always_comb begin
    wd_state_nxt = wd_state_r;
    case (wd_state_r)
      OFW_WD_IDLE:  if (wd_reload) wd_state_nxt = OFW_WD_COUNT;
      OFW_WD_COUNT: begin
        if (wd_drop) wd_state_nxt = OFW_WD_IDLE;
        else if (expire) wd_state_nxt = OFW_WD_PULSE;
      end
      OFW_WD_PULSE: if (pulse_r == 32'h1) wd_state_nxt = OFW_WD_DONE;
      OFW_WD_DONE:  if (wd_reload) wd_state_nxt = OFW_WD_COUNT;
      default:      wd_state_nxt = OFW_WD_IDLE;
    endcase
    // test mode code never starts a normal timeout
    if (wd_state_nxt == OFW_WD_COUNT && wd_state_r != OFW_WD_COUNT
        && new_timer == OFW_TIMER_TEST)
      wd_state_nxt = wd_state_r;
    if (wd_state_r == OFW_WD_COUNT && wd_change && new_timer == OFW_TIMER_TEST)
      wd_state_nxt = OFW_WD_IDLE;
  end

  wire [31:0] new_len = new_scale ? 32'(SCALE1_CYC) : 32'(SCALE0_CYC);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wd_state_r <= OFW_WD_IDLE;
      pre_r      <= 32'h0;
      ticks_r    <= 6'h0;
      pulse_r    <= 32'h0;
    end else begin
      wd_state_r <= wd_state_nxt;
      if (wd_reload) begin
        pre_r   <= new_len - 32'h1;
        ticks_r <= {3'h0, new_timer};
      end else if (counting) begin
        pre_r <= tick ? scale_len - 32'h1 : pre_r - 32'h1;
        if (tick) ticks_r <= ticks_r - 6'h1;
      end
      if (expire) pulse_r <= 32'(PULSE_CYC);
      else if (pulse_r != 32'h0) pulse_r <= pulse_r - 32'h1;
    end
  end

  // outputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cpu_freq_code      <= 5'h00;
      cpu_pll_nm         <= '0;
      src_pll_nm         <= '0;
      smooth_to_src      <= 1'b0;
      smooth_active      <= 1'b0;
      system_reset_out_n <= 1'b1;
      reg_rdata          <= 8'h00;
    end else begin
      cpu_freq_code <= override_r ? {1'b0, sw_cpu_freq_code_r} : straps_r;
      // gear constant comes from the frequency code downstream
      cpu_pll_nm <= cpu_en_r ? '{n: cpu_n_r, m: cpu_m_r}
                             : '{n: hw_n_r, m: hw_m_r};
      src_pll_nm <= '{n: src_en_r ? src_n_r : OFW_N_RST, m: src_table_m};
      // auto hands the circuit to the overclocking pll, cpu first
      smooth_to_src <= sm_manual_r ? sm_src_r : (src_en_r && !cpu_en_r);
      smooth_active <= sm_manual_r || cpu_en_r || src_en_r;
      system_reset_out_n <= !(srst_ok_r && wd_state_nxt == OFW_WD_PULSE);
      reg_rdata <= reg_read ? rdata_nxt : 8'h00;
    end
  end

  always_comb begin
    case (reg_addr)
      OFW_A_CPU_N_LO: rdata_nxt = cpu_n_r[7:0];
      OFW_A_CPU_CTRL: rdata_nxt = {6'h0, cpu_en_r, cpu_n_r[8]};
      OFW_A_CPU_M:    rdata_nxt = {1'b0, cpu_m_r};
      OFW_A_SRC_N_LO: rdata_nxt = src_n_r[7:0];
      OFW_A_SRC_CTRL: rdata_nxt = {6'h0, src_en_r, src_n_r[8]};
      OFW_A_SW_CPU_FREQ_CODE:     rdata_nxt = {3'h0, override_r, sw_cpu_freq_code_r};
      OFW_A_SMOOTH:   rdata_nxt = {6'h0, sm_src_r, sm_manual_r};
      OFW_A_WD_CTRL:  rdata_nxt = {auto_r, recmode_r, rmode_r, scale_r, timer_r, wdog_enable_bit_r};
      OFW_A_REC_N_LO: rdata_nxt = rec_n_r[7:0];
      OFW_A_REC_CTRL: rdata_nxt = {7'h0, rec_n_r[8]};
      OFW_A_STATUS:   rdata_nxt = {3'h0, straps_r[2:0], srst_ok_r, alarm_r};
      OFW_A_EFF_N_LO: rdata_nxt = cpu_pll_nm.n[7:0];
      OFW_A_EFF_M:    rdata_nxt = {1'b0, cpu_pll_nm.m};
      default:        rdata_nxt = 8'h00;
    endcase
  end

  // checks
  property p_pulse_low;
    @(posedge clock) disable iff (reset)
      (expire && srst_ok_r) |=> !system_reset_out_n [*8];
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("reset pulse not driven");

  property p_alarm_set;
    @(posedge clock) disable iff (reset) expire |=> alarm_r;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm not set on expiry");

  property p_strap_block;
    @(posedge clock) disable iff (reset) !srst_ok_r |=> system_reset_out_n;
  endproperty
  a_strap_block: assert property (p_strap_block) else $error("reset without strap");

  property p_idle_after;
    @(posedge clock) disable iff (reset)
      (wd_state_r == OFW_WD_DONE && !wd_reload) |=> wd_state_r == OFW_WD_DONE;
  endproperty
  a_idle_after: assert property (p_idle_after) else $error("watchdog left idle");

  property p_reload;
    @(posedge clock) disable iff (reset)
      (wd_reload && new_timer != OFW_TIMER_TEST) |=> counting && ticks_r == {3'h0, $past(new_timer)};
  endproperty
  a_reload: assert property (p_reload) else $error("countdown not reloaded");

  property p_recover;
    @(posedge clock) disable iff (reset)
      do_recover |=> cpu_n_r == $past(rec_n_sel) && cpu_m_r == $past(rec_m_sel);
  endproperty
  a_recover: assert property (p_recover) else $error("recovery value not loaded");

  property p_override;
    @(posedge clock) disable iff (reset)
      override_r |=> cpu_freq_code == {1'b0, $past(sw_cpu_freq_code_r)};
  endproperty
  a_override: assert property (p_override) else $error("software select ignored");

  property p_src_m;
    @(posedge clock) disable iff (reset) 1'b1 |=> src_pll_nm.m == $past(src_table_m);
  endproperty
  a_src_m: assert property (p_src_m) else $error("src m not fixed");
endmodule
`default_nettype wire

// >>> bench/ofw_sysreset_sink.sv
/*
 * ofw_sysreset_sink: system reset input on the far side of the block.
 * assumes the block's clock; counts pulses and their width in clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module ofw_sysreset_sink (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic rst_in_n,
  output var  int   pulses,
  output var  int   last_width
);
  int run;
  // whole-clock width so a stretched or short pulse shows
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pulses <= 0;
      last_width <= 0;
      run <= 0;
    end else if (!rst_in_n) begin
      run <= run + 1;
    end else if (run != 0) begin
      pulses <= pulses + 1;
      last_width <= run;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
/*
 * tb_top: self-checking bench for the overclock frequency watchdog.
 * assumes shortened watchdog counts; the bench acts as host on the port.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ofw_pkg::*;
  localparam longint P_PULSE = 20;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [4:0] straps = 5'h00;
  logic [4:0] cpu_freq_code;
  logic       srst_strap = 1'b0;
  logic       pg_n = 1'b1;
  logic       smooth_to_src;
  logic       smooth_active;
  logic       srst_n;
  logic [8:0] hw_n = 9'h000;
  logic [6:0] hw_m = 7'h00;
  logic [6:0] src_m = 7'h00;
  ofw_nm_s    cpu_nm;
  ofw_nm_s    src_nm;
  logic [7:0] d;
  logic [4:0] fs;
  int         err_total = 0;
  int         n_compared = 0;
  int         cyc = 0;
  int         pulses, last_width, cnt, cn, cm, sn, rn;

  always #2.5 clock = ~clock;

  ofw_overclock_freq_watchdog #(.PULSE_CYC(P_PULSE), .SCALE0_CYC(10), .SCALE1_CYC(30)) uut (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .freq_select_straps(straps), .system_reset_strap(srst_strap),
    .vtt_power_good_n(pg_n), .hw_strap_n(hw_n), .hw_strap_m(hw_m), .src_table_m(src_m),
    .cpu_freq_code(cpu_freq_code), .cpu_pll_nm(cpu_nm), .src_pll_nm(src_nm),
    .smooth_to_src(smooth_to_src), .smooth_active(smooth_active),
    .system_reset_out_n(srst_n));

  ofw_sysreset_sink sink (.clock(clock), .reset(reset), .rst_in_n(srst_n),
    .pulses(pulses), .last_width(last_width));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // one idle edge so a following strobe is never assigned twice in a step
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    // read data stand only in the cycle after the strobe
    #1 v = reg_rdata;
    @(posedge clock);
  endtask

  task automatic settle;
    repeat (2) @(posedge clock);
  endtask

  // expiry delay gets a few clocks of slack for registered stages
  task automatic expire(input int exp);
    // countdown began at the watchdog write's edge, one or three edges before this task
    cnt = 1;
    while (srst_n === 1'b1 && cnt < 400) begin
      @(negedge clock);
      cnt++;
    end
    chk("expiry delay", (cnt >= exp - 1 && cnt <= exp + 3), 1);
    while (srst_n !== 1'b1 && cnt < 800) begin
      @(negedge clock);
      cnt++;
    end
    settle();
    chk("pulse width", last_width, P_PULSE);
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    void'($urandom(32'haa166cba));
    straps = $urandom;
    hw_n = $urandom;
    hw_m = $urandom;
    src_m = $urandom;
    fs = straps;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    for (int a = 0; a < 10; a++) begin
      rd(a[7:0], d);
      chk("reset value", d, (a == 7) ? 8'h90 : 8'h00);
    end
    rd(8'h3c, d);
    chk("unmapped read", d, 8'h00);
    pg_n <= 1'b0;
    repeat (3) @(posedge clock);
    straps <= ~straps;
    settle();
    chk("strap code", cpu_freq_code, fs);
    chk("hw n m", cpu_nm, {hw_n, hw_m});
    rd(8'h0a, d);
    chk("status", d, {3'h0, fs[2:0], 2'h2});
    for (int c = 0; c < 16; c++) begin
      wr(8'h05, {4'h1, c[3:0]});
      settle();
      chk("sw code", cpu_freq_code, {1'h0, c[3:0]});
    end
    wr(8'h05, 8'h00);
    settle();
    chk("strap code back", cpu_freq_code, fs);
    cn = $urandom_range(511);
    cm = $urandom_range(127);
    sn = $urandom_range(511);
    // values loaded before the enables; n msb and enable written together
    wr(8'h00, cn[7:0]);
    wr(8'h02, {1'h0, cm[6:0]});
    wr(8'h01, {6'h00, 1'h1, cn[8]});
    wr(8'h03, sn[7:0]);
    settle();
    chk("cpu prog", cpu_nm, {cn[8:0], cm[6:0]});
    // byte writes only, never both plls in one block
    wr(8'h04, {6'h00, 1'h1, sn[8]});
    settle();
    chk("src prog", src_nm, {sn[8:0], src_m});
    chk("smooth auto", {smooth_active, smooth_to_src}, 2'h2);
    wr(8'h06, 8'h03);
    settle();
    chk("smooth manual", smooth_to_src, 1'h1);
    wr(8'h06, 8'h01);
    wr(8'h07, 8'hc5);
    wr(8'h00, cn[7:0] ^ 8'h5a); // n alone is allowed
    expire(20);
    chk("auto recovery", cpu_nm, {cn[8:0], cm[6:0]});
    chk("src no recovery", src_nm, {sn[8:0], src_m});
    rd(8'h0a, d);
    chk("alarm set", d[0], 1'h1);
    wr(8'h0a, 8'h01);
    rd(8'h0a, d);
    chk("alarm clear", d[0], 1'h0);
    repeat (40) @(posedge clock);
    chk("idle after pulse", pulses, 1);
    wr(8'h07, 8'hc7);
    repeat (8) @(posedge clock);
    wr(8'h07, 8'hc3);
    expire(10);
    cn = cn ^ 32'h0ff;
    wr(8'h07, 8'he2);
    wr(8'h07, 8'he3);
    wr(8'h00, cn[7:0]);
    expire(10);
    chk("pulse only", cpu_nm, {cn[8:0], cm[6:0]});
    wr(8'h07, 8'h92);
    wr(8'h07, 8'h93);
    expire(30);
    chk("hw recovery", cpu_nm, {hw_n, hw_m});
    rn = $urandom_range(511);
    wr(8'h07, 8'h42);
    wr(8'h08, rn[7:0]);
    wr(8'h09, {7'h00, rn[8]});
    wr(8'h07, 8'h43);
    expire(10);
    chk("user recovery", cpu_nm.n, rn[8:0]);
    wr(8'h07, 8'h80);
    wr(8'h07, 8'h81);
    repeat (60) @(posedge clock);
    chk("test mode timer", pulses, 5);
    srst_strap <= 1'b1;
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    wr(8'h07, 8'h83);
    repeat (40) @(posedge clock);
    chk("reset out disabled", pulses, 0);
    summarize();
  end
endmodule
`default_nettype wire
